//--- verilog/uhw_top.sv
// What this block does
// - first transceiver is wired straight to host port A, no mux.
// - second transceiver goes to device controller when enabled, else host port B.
// - while device owns the shared transceiver, host uses only port A.
// - root hub provides exactly two downstream ports.
// - high speed 480 Mbit/s and full speed 12 Mbit/s devices supported.
// - low speed 1.5 Mbit/s and full speed devices supported on open host.
// - operational registers reached only through the memory mapped slave port.
// - host acts as bus master to fetch, read, write back and retire descriptors.
// - bus error or misaligned access sets the unrecoverable error flag.
// - root hub register reports the downstream port count.
// - device attach detected per port in hardware without polling.
// - data lines driven only by the transceivers, under host control except transceiver 1 while the device controller is enabled.
// - without utmi loop lock no high speed; full speed stays possible.
// - transceiver returns a 30 MHz clock used by transceiver side logic.
// - full speed clocks are 48 MHz and 48/4, within 0.25 percent.
// - one interrupt line to the system interrupt controller.
// - up to 127 addressable devices in tiered star.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uhw_top #(
  parameter int DEB_CYC = uhw_pkg::DEB_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire uhw_pkg::uhw_apb_req_s apb_req,
  output uhw_pkg::uhw_apb_rsp_s apb_rsp,
  // ahb master
  output uhw_pkg::uhw_ahbm_s ahbm,
  input wire uhw_pkg::uhw_ahbs_s ahbs,
  // port drive from host core and device controller
  input wire uhw_pkg::uhw_pin_s host_port_a,
  input wire uhw_pkg::uhw_pin_s host_port_b,
  input wire uhw_pkg::uhw_pin_s hs_dev_drive,
  input wire logic device_ctrl_enable,
  // transceivers
  output uhw_pkg::uhw_pin_s xcvr0_drive,
  output uhw_pkg::uhw_pin_s xcvr1_drive,
  input wire uhw_pkg::uhw_xin_s xcvr0_line,
  input wire uhw_pkg::uhw_xin_s xcvr1_line,
  input wire logic utmi_loop_locked_flag,
  input wire logic phy_clk_30m,
  // clock manager configuration
  output logic fs_clock_source_select,
  output logic [3:0] fs_clock_divider,
  // interrupt
  output logic irq
);
  import uhw_pkg::*;

  // synchroniser lanes: three per transceiver line group, then lock and phy clock
  localparam int XW = 3;
  localparam int SY_LOCK = 2 * XW;
  localparam int SY_CLK = 2 * XW + 1;
  localparam int SYW = 2 * XW + 2;

  typedef struct packed {
    logic [SYW-1:0] sy1;
    logic [SYW-1:0] sy2;
    logic clk_d;
    logic [2:0] alive;
    logic run;
    logic fssel;
    logic [DIV_W-1:0] div;
    logic go;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] ien;
    logic [31:0] dadr;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
  } uhw_top_st_s;

  uhw_top_st_s st_ff;
  uhw_top_st_s nxt_st;

  logic [NUM_PORTS-1:0] conn;
  logic [NUM_PORTS-1:0] chg;
  logic [NUM_PORTS-1:0] owned;
  uhw_speed_e spd [NUM_PORTS];
  logic [XW-1:0] line_s [NUM_PORTS];
  logic lock_s;
  logic hs_avail;
  logic div_bad;
  logic f_busy;
  logic f_done;
  logic f_err;
  logic [31:0] f_rdata;
  logic setup;
  logic wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFF_CTRL) | hit(a, OFF_STAT) | hit(a, OFF_IEN) |
      hit(a, OFF_HUB) | hit(a, OFF_DADR) | hit(a, OFF_DDAT);
  endfunction

  // port routing
  assign xcvr0_drive = host_port_a;
  assign xcvr1_drive = device_ctrl_enable ? hs_dev_drive : host_port_b;

  assign lock_s = st_ff.sy2[SY_LOCK];
  assign hs_avail = lock_s & st_ff.run;
  assign div_bad = st_ff.fssel & (st_ff.div != DIV_UTMI);
  assign line_s[0] = st_ff.sy2[XW-1:0];
  assign line_s[1] = st_ff.sy2[2*XW-1:XW];
  assign owned[0] = 1'b1;
  assign owned[1] = ~device_ctrl_enable;

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      uhw_attach #(.DEB_CYC(DEB_CYC)) u_attach (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .line_dp(line_s[p][0]),
        .line_dm(line_s[p][1]),
        .hs_ok(line_s[p][2] & hs_avail),
        .owned(owned[p]),
        .conn(conn[p]),
        .speed(spd[p]),
        .chg(chg[p])
      );
    end
  endgenerate

  uhw_fetch u_fetch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .go(st_ff.go),
    .addr(st_ff.dadr),
    .busy(f_busy),
    .done(f_done),
    .err(f_err),
    .rdata(f_rdata),
    .ahbm(ahbm),
    .ahbs(ahbs)
  );

  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

  always_comb begin
    logic [31:0] rd;
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] clr;
    rd = '0;
    set = '0;
    clr = '0;
    nxt_st = st_ff;
    // two flops on every pin-side input; only sy2 feeds logic
    nxt_st.sy1 = {phy_clk_30m, utmi_loop_locked_flag, xcvr1_line, xcvr0_line};
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.clk_d = st_ff.sy2[SY_CLK];
    // a returned phy clock that keeps toggling marks the transceiver side alive
    if (st_ff.clk_d != st_ff.sy2[SY_CLK]) begin
      nxt_st.alive = ALIVE_WIN;
    end else if (st_ff.alive != 3'h0) begin
      nxt_st.alive = st_ff.alive - 1'b1;
    end
    // go is refused while a fetch runs; software polls busy first
    nxt_st.go = 1'b0;
    if (wr) begin
      if (hit(apb_req.paddr, OFF_CTRL)) begin
        nxt_st.run = apb_req.pwdata[CT_RUN];
        nxt_st.fssel = apb_req.pwdata[CT_FSSEL];
        nxt_st.div = apb_req.pwdata[CT_DIV_LSB +: DIV_W];
        nxt_st.go = apb_req.pwdata[CT_GO] & ~f_busy;
      end
      if (hit(apb_req.paddr, OFF_STAT)) begin
        clr = apb_req.pwdata[ST_W-1:0];
      end
      if (hit(apb_req.paddr, OFF_IEN)) begin
        nxt_st.ien = apb_req.pwdata[ST_W-1:0];
      end
      if (hit(apb_req.paddr, OFF_DADR)) begin
        nxt_st.dadr = apb_req.pwdata;
      end
    end
    set[ST_UERR] = f_err;
    set[ST_CC_LSB +: NUM_PORTS] = chg;
    set[ST_DONE] = f_done;
    // set beats a write-one-to-clear in the same cycle
    nxt_st.stat = (st_ff.stat & ~clr) | set;
    // registered so the line never glitches during a status write
    nxt_st.irq = |(st_ff.stat & st_ff.ien);
    if (setup) begin
      case (apb_req.paddr)
        OFF_CTRL: begin
          rd[CT_RUN] = st_ff.run;
          rd[CT_FSSEL] = st_ff.fssel;
          rd[CT_BUSY] = f_busy;
          rd[CT_DIV_LSB +: DIV_W] = st_ff.div;
        end
        OFF_STAT: begin
          rd[ST_W-1:0] = st_ff.stat;
        end
        OFF_IEN: begin
          rd[ST_W-1:0] = st_ff.ien;
        end
        OFF_HUB: begin
          rd[7:0] = NDP_VAL;
          rd[HUB_CONN_LSB +: NUM_PORTS] = conn;
          rd[HUB_SPD_LSB +: 2] = spd[0];
          rd[HUB_SPD_LSB + 2 +: 2] = spd[1];
          rd[HUB_HSAV] = hs_avail;
          rd[HUB_PHY] = (st_ff.alive != 3'h0);
          rd[HUB_DIVB] = div_bad;
          rd[HUB_MAXD_LSB +: 7] = MAX_DEV;
        end
        OFF_DADR: begin
          rd = st_ff.dadr;
        end
        OFF_DDAT: begin
          rd = f_rdata;
        end
        default: begin
          rd = '0;
        end
      endcase
      nxt_st.prdata = rd;
      nxt_st.pslverr = ~mapped(apb_req.paddr);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero wait state: read data is captured in the setup cycle
  assign apb_rsp.prdata = st_ff.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = st_ff.pslverr;
  assign fs_clock_source_select = st_ff.fssel;
  assign fs_clock_divider = st_ff.div;
  assign irq = st_ff.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_port_a;
    xcvr0_drive == host_port_a && xcvr0_drive.oe == host_port_a.oe;
  endproperty
  a_port_a: assert property (p_port_a) else $error("port A not wired to transceiver 0");

  property p_dev_owns;
    device_ctrl_enable |-> xcvr1_drive == hs_dev_drive;
  endproperty
  a_dev_owns: assert property (p_dev_owns) else $error("device controller lost transceiver 1");

  property p_host_b;
    !device_ctrl_enable |-> xcvr1_drive == host_port_b;
  endproperty
  a_host_b: assert property (p_host_b) else $error("port B not routed to transceiver 1");

  property p_b_dropped;
    device_ctrl_enable |=> !conn[1];
  endproperty
  a_b_dropped: assert property (p_b_dropped) else $error("port B still connected under device");

  property p_ndp;
    (setup && apb_req.paddr == OFF_HUB) |=> apb_rsp.prdata[7:0] == NDP_VAL && !apb_rsp.pslverr;
  endproperty
  a_ndp: assert property (p_ndp) else $error("hub port count wrong");

  property p_uerr;
    f_err |=> st_ff.stat[ST_UERR] ##1 st_ff.irq == st_ff.ien[ST_UERR] || st_ff.irq;
  endproperty
  a_uerr: assert property (p_uerr) else $error("unrecoverable error not flagged");

  property p_irq;
    (|(st_ff.stat & st_ff.ien)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("pending enabled event without interrupt");

  property p_hs_lock;
    (!lock_s && !$past(lock_s)) |-> spd[0] != SPD_HS && spd[1] != SPD_HS;
  endproperty
  a_hs_lock: assert property (p_hs_lock) else $error("high speed without utmi lock");

  property p_unmapped;
    (setup && !mapped(apb_req.paddr)) |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_go_start;
    st_ff.go |=> f_busy || f_err;
  endproperty
  a_go_start: assert property (p_go_start) else $error("fetch request not taken");

  property p_done_set;
    f_done |=> st_ff.stat[ST_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("fetch done not flagged");

  property p_cc_set;
    (|chg) |=> (st_ff.stat[ST_CC_LSB +: NUM_PORTS] & $past(chg)) == $past(chg);
  endproperty
  a_cc_set: assert property (p_cc_set) else $error("connect change not flagged");

  property p_stat_clr;
    (wr && hit(apb_req.paddr, OFF_STAT) && apb_req.pwdata[ST_DONE] && !f_done) |=> !st_ff.stat[ST_DONE];
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("done flag not cleared by write");

  property p_ien_mask;
    !(|(st_ff.stat & st_ff.ien)) |=> !irq;
  endproperty
  a_ien_mask: assert property (p_ien_mask) else $error("interrupt without enabled event");

  property p_fs_cfg;
    (wr && hit(apb_req.paddr, OFF_CTRL)) |=>
      fs_clock_divider == $past(apb_req.pwdata[CT_DIV_LSB +: DIV_W]) &&
      fs_clock_source_select == $past(apb_req.pwdata[CT_FSSEL]);
  endproperty
  a_fs_cfg: assert property (p_fs_cfg) else $error("clock configuration not applied");

  property p_dadr_wr;
    (wr && hit(apb_req.paddr, OFF_DADR)) |=> st_ff.dadr == $past(apb_req.pwdata);
  endproperty
  a_dadr_wr: assert property (p_dadr_wr) else $error("descriptor address write lost");

  property p_alive;
    (st_ff.clk_d != st_ff.sy2[SY_CLK]) |=> st_ff.alive == ALIVE_WIN;
  endproperty
  a_alive: assert property (p_alive) else $error("phy clock toggle not seen");

  c_dev_take: cover property ($rose(device_ctrl_enable));
  c_attach: cover property ($rose(conn[0]));
  c_fetch_done: cover property (f_done);
  c_uerr_irq: cover property (st_ff.stat[ST_UERR] && irq);
  c_low_speed: cover property (conn[1] && spd[1] == SPD_LS);

endmodule
`default_nettype wire

//--- verilog/uhw_pkg.sv
package uhw_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IEN = 8'h08;
  localparam logic [7:0] OFF_HUB = 8'h0C;
  localparam logic [7:0] OFF_DADR = 8'h10;
  localparam logic [7:0] OFF_DDAT = 8'h14;

  // control fields
  localparam int CT_RUN = 0;
  localparam int CT_FSSEL = 1;
  localparam int CT_GO = 2;
  localparam int CT_BUSY = 3;
  localparam int CT_DIV_LSB = 4;
  localparam int DIV_W = 4;
  localparam logic [3:0] DIV_UTMI = 4'h9;

  // status and enable fields
  localparam int ST_W = 4;
  localparam int ST_UERR = 0;
  localparam int ST_CC_LSB = 1;
  localparam int ST_DONE = 3;

  // root hub fields
  localparam int NUM_PORTS = 2;
  localparam logic [7:0] NDP_VAL = 8'h02;
  localparam logic [6:0] MAX_DEV = 7'h7F;
  localparam int HUB_CONN_LSB = 8;
  localparam int HUB_SPD_LSB = 10;
  localparam int HUB_HSAV = 14;
  localparam int HUB_PHY = 15;
  localparam int HUB_DIVB = 16;
  localparam int HUB_MAXD_LSB = 17;

  // timing
  localparam int CLK_NS = 40;
  localparam int DEB_NS = 100000;
  localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] ALIVE_WIN = 3'h7;

  // ahb codes and descriptor retire bit
  localparam logic [1:0] HT_IDLE = 2'h0;
  localparam logic [1:0] HT_NONSEQ = 2'h2;
  localparam logic [2:0] HS_WORD = 3'h2;
  localparam logic [31:0] RETIRE_MASK = 32'h8000_0000;

  typedef enum logic [1:0] {SPD_FS = 2'h0, SPD_LS = 2'h1, SPD_HS = 2'h2} uhw_speed_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } uhw_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uhw_apb_rsp_s;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } uhw_ahbm_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } uhw_ahbs_s;

  // drive toward a transceiver
  typedef struct packed {
    logic dp;
    logic dm;
    logic oe;
  } uhw_pin_s;

  // line state back from a transceiver
  typedef struct packed {
    logic hs_ok;
    logic dm;
    logic dp;
  } uhw_xin_s;

endpackage

//--- verilog/uhw_attach.sv
`timescale 1ns/1ps
`default_nettype none
module uhw_attach #(
  parameter int DEB_CYC = uhw_pkg::DEB_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // synchronised line state and port ownership
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic hs_ok,
  input wire logic owned,
  // port status
  output logic conn,
  output uhw_pkg::uhw_speed_e speed,
  output logic chg
);
  import uhw_pkg::*;

  localparam int CW = $clog2(DEB_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic conn;
    uhw_speed_e speed;
    logic chg;
  } uhw_att_s;

  uhw_att_s st_ff;
  uhw_att_s nxt_st;
  logic raw;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.chg = 1'b0;
    raw = owned & (line_dp | line_dm);
    if (!owned) begin
      // port taken away: report it gone at once
      nxt_st.cnt = '0;
      nxt_st.conn = 1'b0;
      nxt_st.speed = SPD_FS;
      nxt_st.chg = st_ff.conn;
    end else if (raw == st_ff.conn) begin
      nxt_st.cnt = '0;
      if (st_ff.conn && st_ff.speed != SPD_LS) begin
        nxt_st.speed = hs_ok ? SPD_HS : SPD_FS;
      end
    end else if (st_ff.cnt == CW'(DEB_CYC - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.conn = raw;
      nxt_st.chg = 1'b1;
      if (!raw) begin
        nxt_st.speed = SPD_FS;
      end else if (line_dm) begin
        nxt_st.speed = SPD_LS;
      end else begin
        nxt_st.speed = hs_ok ? SPD_HS : SPD_FS;
      end
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign conn = st_ff.conn;
  assign speed = st_ff.speed;
  assign chg = st_ff.chg;

endmodule
`default_nettype wire

//--- verilog/uhw_fetch.sv
`timescale 1ns/1ps
`default_nettype none
module uhw_fetch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // request
  input wire logic go,
  input wire logic [31:0] addr,
  // result
  output logic busy,
  output logic done,
  output logic err,
  output logic [31:0] rdata,
  // ahb master
  output uhw_pkg::uhw_ahbm_s ahbm,
  input wire uhw_pkg::uhw_ahbs_s ahbs
);
  import uhw_pkg::*;

  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_RADR = 3'b001,
    F_RDAT = 3'b011,
    F_WADR = 3'b010,
    F_WDAT = 3'b110
  } uhw_fst_e;

  typedef struct packed {
    uhw_fst_e st;
    logic [31:0] addr;
    logic [31:0] data;
    logic done;
    logic err;
  } uhw_fet_s;

  uhw_fet_s st_ff;
  uhw_fet_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.err = 1'b0;
    case (st_ff.st)
      F_IDLE: begin
        if (go) begin
          if (addr[1:0] != 2'h0) begin
            nxt_st.err = 1'b1;
          end else begin
            nxt_st.addr = addr;
            nxt_st.st = F_RADR;
          end
        end
      end
      F_RADR: begin
        if (ahbs.hready) begin
          nxt_st.st = F_RDAT;
        end
      end
      F_RDAT: begin
        if (ahbs.hresp) begin
          nxt_st.err = 1'b1;
          nxt_st.st = F_IDLE;
        end else if (ahbs.hready) begin
          nxt_st.data = ahbs.hrdata;
          nxt_st.st = F_WADR;
        end
      end
      F_WADR: begin
        if (ahbs.hready) begin
          nxt_st.st = F_WDAT;
        end
      end
      F_WDAT: begin
        if (ahbs.hresp) begin
          nxt_st.err = 1'b1;
          nxt_st.st = F_IDLE;
        end else if (ahbs.hready) begin
          nxt_st.done = 1'b1;
          nxt_st.st = F_IDLE;
        end
      end
      default: begin
        nxt_st.st = F_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // read the descriptor, then write it back with its retire bit set
  always_comb begin
    ahbm.haddr = st_ff.addr;
    ahbm.htrans = (st_ff.st == F_RADR || st_ff.st == F_WADR) ? HT_NONSEQ : HT_IDLE;
    ahbm.hwrite = (st_ff.st == F_WADR);
    ahbm.hsize = HS_WORD;
    ahbm.hwdata = st_ff.data | RETIRE_MASK;
  end

  assign busy = (st_ff.st != F_IDLE);
  assign done = st_ff.done;
  assign err = st_ff.err;
  assign rdata = st_ff.data;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_misalign;
    (st_ff.st == F_IDLE && go && addr[1:0] != 2'h0) |=> err && !busy;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned fetch not flagged");

  property p_addr_hold;
    (ahbm.htrans == HT_NONSEQ && !ahbs.hready) |=> $stable(ahbm.haddr) && ahbm.htrans == HT_NONSEQ;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("ahb address dropped while stalled");

endmodule
`default_nettype wire

//--- test/uhw_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module uhw_far_side #(
  parameter logic [31:0] INIT = 32'h0000_1234
) (
  // clock
  input wire logic ref_clk,
  // attach and bus controls from the bench
  input wire logic [1:0] plug,
  input wire logic [1:0] low_spd,
  input wire logic hs_chirp,
  input wire logic bus_err,
  input wire logic slow,
  // transceiver line state
  output uhw_pkg::uhw_xin_s xcvr0_line,
  output uhw_pkg::uhw_xin_s xcvr1_line,
  // memory side of the master bus
  input wire uhw_pkg::uhw_ahbm_s ahbm,
  output uhw_pkg::uhw_ahbs_s ahbs,
  output logic [31:0] mem_word,
  output logic [31:0] last_addr
);
  import uhw_pkg::*;
  logic dph_ff = 1'b0;
  logic wr_ff = 1'b0;
  logic [7:0] scr_ff = 8'h00;
  logic [31:0] mem_ff = INIT;
  logic [31:0] adr_ff = 32'h0000_0000;
  // unplugged lines fall to the host pull-downs
  assign xcvr0_line = '{hs_ok: plug[0] & hs_chirp, dm: plug[0] & low_spd[0], dp: plug[0] & ~low_spd[0]};
  assign xcvr1_line = '{hs_ok: plug[1] & hs_chirp, dm: plug[1] & low_spd[1], dp: plug[1] & ~low_spd[1]};
  // slow mode stalls every other cycle to stretch both phases
  assign ahbs.hready = ~slow | scr_ff[0];
  assign ahbs.hresp = dph_ff & bus_err;
  // outside a data phase the read bus carries churn, not stale data
  assign ahbs.hrdata = dph_ff ? mem_ff : {4{scr_ff}};
  assign mem_word = mem_ff;
  assign last_addr = adr_ff;
  always @(posedge ref_clk) begin
    scr_ff <= scr_ff + 8'h5B;
    if (ahbs.hready) begin
      if (dph_ff && wr_ff && !bus_err) begin
        mem_ff <= ahbm.hwdata;
      end
      dph_ff <= (ahbm.htrans == HT_NONSEQ);
      wr_ff <= ahbm.hwrite;
      if (ahbm.htrans == HT_NONSEQ) begin
        adr_ff <= ahbm.haddr;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uhw_pkg::*;
  localparam int DEB = 8;
  localparam logic [31:0] INIT = 32'h0000_1234;
  logic ref_clk;
  logic rst_b;
  uhw_apb_req_s apb_req;
  uhw_apb_rsp_s apb_rsp;
  uhw_ahbm_s ahbm;
  uhw_ahbs_s ahbs;
  uhw_pin_s hpa, hpb, hsd, x0d, x1d;
  uhw_xin_s x0l, x1l;
  logic dce, lock, phy, phy_run, fsel, irq, hs_chirp, bus_err, slow;
  logic [3:0] fdiv;
  logic [1:0] plug, low_spd;
  logic [31:0] mem_word, last_addr, rd_q;
  logic rd_e;
  int failures = 0;
  int checks = 0;

  uhw_top #(.DEB_CYC(DEB)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ahbm(ahbm), .ahbs(ahbs), .host_port_a(hpa), .host_port_b(hpb), .hs_dev_drive(hsd),
    .device_ctrl_enable(dce), .xcvr0_drive(x0d), .xcvr1_drive(x1d), .xcvr0_line(x0l), .xcvr1_line(x1l),
    .utmi_loop_locked_flag(lock), .phy_clk_30m(phy), .fs_clock_source_select(fsel),
    .fs_clock_divider(fdiv), .irq(irq));

  uhw_far_side #(.INIT(INIT)) i_far (.ref_clk(ref_clk), .plug(plug), .low_spd(low_spd), .hs_chirp(hs_chirp),
    .bus_err(bus_err), .slow(slow), .xcvr0_line(x0l), .xcvr1_line(x1l), .ahbm(ahbm), .ahbs(ahbs),
    .mem_word(mem_word), .last_addr(last_addr));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy <= 1'b0;
    end else if (phy_run) begin
      phy <= ~phy;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one transfer; an idle edge after release keeps drives one per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    // only the watchdog ends a stalled access
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd_q = apb_rsp.prdata;
    rd_e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q & m, exp);
  endtask

  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (rd_q[b] !== 1'b1 && n < 40);
    chk({31'h0, rd_q[b]}, 32'h1);
  endtask

  task automatic t_regs;
    rdc(OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdc(OFF_HUB, 32'h00FE_00FF, {8'h00, MAX_DEV, 9'h000, NDP_VAL});
    wr(OFF_HUB, 32'h0);
    rdc(OFF_HUB, 32'h00FE_00FF, {8'h00, MAX_DEV, 9'h000, NDP_VAL});
    apb(1'b0, 8'h18, 32'h0);
    chk({rd_q[30:0], rd_e}, 32'h1);
  endtask

  task automatic t_mux;
    hpa <= 3'h5;
    hpb <= 3'h3;
    hsd <= 3'h6;
    for (int m = 0; m < 2; m++) begin
      dce <= m[0];
      cyc(2);
      chk({29'h0, x0d}, {29'h0, hpa});
      chk({29'h0, x1d}, m ? {29'h0, hsd} : {29'h0, hpb});
    end
    dce <= 1'b0;
  endtask

  task automatic t_attach;
    lock <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    hs_chirp <= 1'b1;
    low_spd <= 2'b10;
    plug <= 2'b11;
    cyc(DEB + 6);
    rdc(OFF_HUB, 32'h0000_7F00, {17'h0, 1'b1, SPD_LS, SPD_HS, 2'b11, 8'h00});
    rdc(OFF_STAT, 32'h6, 32'h6);
    wr(OFF_STAT, 32'h6);
    rdc(OFF_STAT, 32'h6, 32'h0);
    lock <= 1'b0;
    cyc(4);
    rdc(OFF_HUB, 32'h0000_4C00, 32'h0);
    dce <= 1'b1;
    cyc(3);
    rdc(OFF_HUB, 32'h0000_0300, 32'h0000_0100);
    dce <= 1'b0;
    plug <= 2'b00;
    cyc(DEB + 6);
    wr(OFF_STAT, 32'hF);
  endtask

  task automatic t_clock;
    lock <= 1'b1;
    wr(OFF_CTRL, {24'h0, DIV_UTMI, 4'h2});
    chk({27'h0, fsel, fdiv}, {27'h0, 1'b1, DIV_UTMI});
    rdc(OFF_HUB, 32'h0001_0000, 32'h0);
    wr(OFF_CTRL, 32'h0000_0082);
    rdc(OFF_HUB, 32'h0001_0000, 32'h0001_0000);
    wr(OFF_CTRL, 32'h0000_0030);
    chk({27'h0, fsel, fdiv}, 32'h3);
    rdc(OFF_HUB, 32'h0001_0000, 32'h0);
    phy_run <= 1'b1;
    cyc(12);
    rdc(OFF_HUB, 32'h0000_8000, 32'h0000_8000);
    phy_run <= 1'b0;
    cyc(12);
    rdc(OFF_HUB, 32'h0000_8000, 32'h0);
  endtask

  task automatic t_fetch;
    wr(OFF_IEN, 32'h9);
    wr(OFF_DADR, 32'h0000_0100);
    slow <= 1'b1;
    wr(OFF_CTRL, 32'h4);
    wait_stat(ST_DONE);
    chk(last_addr, 32'h0000_0100);
    chk(mem_word, INIT | RETIRE_MASK);
    rdc(OFF_DDAT, 32'hFFFF_FFFF, INIT);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IEN, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IEN, 32'h9);
    wr(OFF_STAT, 32'h8);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_DADR, 32'h0000_0102);
    wr(OFF_CTRL, 32'h4);
    wait_stat(ST_UERR);
    chk(last_addr, 32'h0000_0100);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_STAT, 32'hF);
    // stale OFF_DDAT word shows the read data was not captured after the abort
    bus_err <= 1'b1;
    wr(OFF_DADR, 32'h0000_0200);
    wr(OFF_CTRL, 32'h4);
    wait_stat(ST_UERR);
    bus_err <= 1'b0;
    chk(mem_word, INIT | RETIRE_MASK);
    chk(last_addr, 32'h0000_0200);
    rdc(OFF_DDAT, 32'hFFFF_FFFF, INIT);
    wr(OFF_STAT, 32'hF);
    slow <= 1'b0;
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    tally_and_finish;
  end

  initial begin
    rst_b = 1'b0;
    apb_req = '0;
    hpa = '0;
    hpb = '0;
    hsd = '0;
    dce = 1'b0;
    lock = 1'b0;
    phy_run = 1'b0;
    hs_chirp = 1'b0;
    bus_err = 1'b0;
    slow = 1'b0;
    plug = 2'b00;
    low_spd = 2'b00;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_mux;
    t_attach;
    t_clock;
    t_fetch;
    tally_and_finish;
  end
endmodule
`default_nettype wire
